// *** serial_bit_io_port.sv ***
// Purpose: Eight-bit I/O port reached from an SPI master, with Wishbone status.
// Assumes: SCK is well below the system clock; it is sampled, not used as a clock.
// Notes:   Link pins pass a two flip-flop synchroniser before any logic.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module serial_bit_io_port
  import serial_bit_io_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Serial link.
  input  wire logic        ce_n_i,
  input  wire logic        sck_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // Hardwired identify pins.
  input  wire logic        identify_pin_high_i,
  input  wire logic        identify_pin_low_i,
  // Port pins.
  input  wire logic [7:0]  port_pins_i,
  output logic      [7:0]  port_pins_o,
  output logic      [7:0]  port_pins_oe_o,
  // Interrupt.
  output logic             irq_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_DATA,
    ST_DONE,
    ST_SKIP
  } state_e;

  state_e          state_q;
  link_s           link_raw;
  link_s           link_s_q;
  logic [7:0]      pins_sync;
  logic            sck_prev_q;
  logic            ce_prev_q;
  logic            pol_q;
  logic            flag_q;
  logic [2:0]      bit_q;
  logic [7:0]      shift_q;
  ctrl_s           ctrl_q;
  logic [1:0]      mode_q;
  logic [7:0]      data_q;
  logic [7:0]      dir_q;
  logic            miso_q;
  logic            miso_oe_q;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] status_d;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clear_bits;
  logic            ack_q;
  logic [31:0]     dat_q;
  logic            irq_q;

  logic            selected;
  logic            ce_fall;
  logic            lead;
  logic            trail;
  logic            byte_done;
  logic            id_check;
  logic            id_match;
  logic [7:0]      rx_byte;
  ctrl_s           ctrl_new;
  logic [7:0]      port_view;
  logic            flag_now;
  logic [7:0]      ctrl_read;
  logic [7:0]      data_read;
  logic [7:0]      write_target;
  logic [7:0]      write_value;
  logic            write_commit;
  logic            read_byte;
  logic            bus_access;
  logic            bus_write;

  // Link pins are asynchronous, so they go through two flip-flops first.
  assign link_raw = '{ce_n: ce_n_i, sck: sck_i, mosi: mosi_i,
                      id_high: identify_pin_high_i, id_low: identify_pin_low_i};

  link_sync #(
    .WIDTH ($bits(link_s))
  ) u_link_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (link_raw),
    .sync_o  (link_s_q)
  );

  // Port pin levels are synchronised the same way.
  link_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (port_pins_i),
    .sync_o  (pins_sync)
  );

  // Read view of the port and the live compare condition.
  port_compare u_port_compare (
    .mode_i (mode_q),
    .data_i (data_q),
    .dir_i  (dir_q),
    .pins_i (pins_sync),
    .view_o (port_view),
    .flag_o (flag_now)
  );

  // Edge detection; the polarity decides which SCK edge is leading.
  // The chip enable edge itself is kept out of the SCK edge terms so that
  // the stale polarity of the last frame can never fake a bit.
  assign selected = ~link_s_q.ce_n;
  assign ce_fall  = ce_prev_q & ~link_s_q.ce_n;
  assign lead     = selected & ~ce_fall & (sck_prev_q == pol_q) & (link_s_q.sck != pol_q);
  assign trail    = selected & ~ce_fall & (sck_prev_q != pol_q) & (link_s_q.sck == pol_q);
  assign rx_byte  = {shift_q[6:0], link_s_q.mosi};
  assign ctrl_new = ctrl_s'(rx_byte);
  assign byte_done = trail & (bit_q == LAST_BIT);

  // Identify bits arrive as the first two bits of the control byte.
  assign id_check = trail & (state_q == ST_CTRL) & (bit_q == ID_LAST_BIT);
  assign id_match = ({shift_q[0], link_s_q.mosi} == {link_s_q.id_high, link_s_q.id_low});

  // Register value that a given control byte would shift out.
  assign ctrl_read = ctrl_new.register_select_bit ? dir_q : port_view;
  assign data_read = ctrl_q.register_select_bit ? dir_q : port_view;

  // Write merge: plain replace or a set or clear mask.
  assign write_target = ctrl_q.register_select_bit ? dir_q : data_q;
  always_comb
  begin
    if (!ctrl_q.format_mask_bit)
    begin
      write_value = rx_byte;
    end
    else if (ctrl_q.format_setclear_bit)
    begin
      write_value = write_target | rx_byte;
    end
    else
    begin
      write_value = write_target & ~rx_byte;
    end
  end

  assign write_commit = byte_done & (state_q == ST_DATA) & ctrl_q.write;
  assign read_byte    = byte_done & (state_q == ST_DATA) & ~ctrl_q.write;

  // Previous sampled levels reset low, as the synchroniser does, so no false chip enable edge follows reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_prev_q <= 1'b0;
      ce_prev_q  <= 1'b0;
    end
    else
    begin
      sck_prev_q <= link_s_q.sck;
      ce_prev_q  <= link_s_q.ce_n;
    end
  end

  // Idle clock polarity and compare flag are caught as chip enable falls.
  // Every device does this, selected by its identify bits or not.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pol_q  <= 1'b0;
      flag_q <= 1'b0;
    end
    else if (ce_fall)
    begin
      pol_q  <= link_s_q.sck;
      flag_q <= flag_now;
    end
  end

  // Frame sequence: control byte, then read bytes until chip enable rises, or a single write byte.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !selected)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (ce_fall)
          begin
            state_q <= ST_CTRL;
          end
        end
        ST_CTRL:
        begin
          if (id_check && !id_match)
          begin
            state_q <= ST_SKIP;
          end
          else if (byte_done)
          begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (write_commit)
          begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          state_q <= ST_DONE;
        end
        ST_SKIP:
        begin
          state_q <= ST_SKIP;
        end
      endcase
    end
  end

  // Bit counter inside the current byte.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ce_fall)
    begin
      bit_q <= 3'h0;
    end
    else if (trail)
    begin
      bit_q <= bit_q + 3'h1;
    end
  end

  // The single shift register carries both directions of every byte.
  // It is preloaded with the flag, so the control byte sends only the flag.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shift_q <= 8'h00;
    end
    else if (ce_fall)
    begin
      shift_q <= {8{flag_now}};
    end
    else if (byte_done && state_q == ST_CTRL)
    begin
      shift_q <= ctrl_read;
    end
    else if (read_byte)
    begin
      shift_q <= data_read;
    end
    else if (trail)
    begin
      shift_q <= rx_byte;
    end
  end

  // Control byte is kept for the whole frame once it has been taken.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= ctrl_s'(8'h00);
      mode_q <= MODE_RST;
    end
    else if (byte_done && state_q == ST_CTRL)
    begin
      ctrl_q <= ctrl_new;
      mode_q <= ctrl_new.compare_mode;
    end
  end

  // Data and direction registers change only when a write byte completes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_q <= DATA_RST;
      dir_q  <= DIR_RST;
    end
    else if (write_commit)
    begin
      if (ctrl_q.register_select_bit)
      begin
        dir_q <= write_value;
      end
      else
      begin
        data_q <= write_value;
      end
    end
  end

  // MISO leaves high impedance only after the identify bits matched.
  // Keeping it off for the first two bits avoids contention between
  // devices that share one chip enable.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !selected || write_commit)
    begin
      miso_oe_q <= 1'b0;
    end
    else if (id_check && id_match)
    begin
      miso_oe_q <= 1'b1;
    end
  end

  // Out bit changes on the leading edge, as clock phase one expects.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      miso_q <= 1'b0;
    end
    else if (lead)
    begin
      miso_q <= shift_q[7];
    end
  end

  // Events for the interrupt status register.
  always_comb
  begin
    events           = '0;
    events[EV_WRITE] = write_commit;
    events[EV_READ]  = read_byte;
    events[EV_MATCH] = ce_fall & flag_now;
    events[EV_SKIP]  = id_check & ~id_match;
  end

  // Wishbone decode; one access per request, acked the next cycle.
  assign bus_access = cyc_i & stb_i & ~ack_q;
  assign bus_write  = bus_access & we_i & sel_i[0];
  assign clear_bits = (bus_write && adr_i == STATUS_OFS) ? dat_i[EV_W-1:0] : '0;

  // A new event in the clearing cycle wins over the clear.
  assign status_d = (status_q & ~clear_bits) | events;

  // Sticky status, mask and the level interrupt.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_q <= '0;
      mask_q   <= MASK_RST;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
      if (bus_write && adr_i == MASK_OFS)
      begin
        mask_q <= dat_i[EV_W-1:0];
      end
    end
  end

  // Read data and acknowledge; unmapped offsets read zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= bus_access;
      if (bus_access)
      begin
        dat_q <= 32'h0000_0000;
        unique case (adr_i)
          STATUS_OFS: dat_q[EV_W-1:0] <= status_q;
          MASK_OFS:   dat_q[EV_W-1:0] <= mask_q;
          VIEW_OFS:
          begin
            dat_q[7:0]             <= ctrl_q;
            dat_q[VIEW_FLAG_BIT]   <= flag_q;
            dat_q[VIEW_POL_BIT]    <= pol_q;
            dat_q[VIEW_ACTIVE_BIT] <= miso_oe_q;
          end
          PORT_OFS:
          begin
            dat_q[7:0]                         <= data_q;
            dat_q[PORT_DIR_LSB+7:PORT_DIR_LSB] <= dir_q;
            dat_q[PORT_PIN_LSB+7:PORT_PIN_LSB] <= pins_sync;
          end
          default:    dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // All outputs come straight from flip-flops.
  assign dat_o          = dat_q;
  assign ack_o          = ack_q;
  assign miso_o         = miso_q;
  assign miso_oe_o      = miso_oe_q;
  assign port_pins_o    = data_q;
  assign port_pins_oe_o = dir_q;
  assign irq_o          = irq_q;

endmodule // serial_bit_io_port

`default_nettype wire

// *** serial_bit_io_pkg.sv ***
// Purpose: Shared constants and carrier types for the serial bit I/O port.
// Assumes: One 50 MHz system clock; the serial link is sampled, not clocked.
// Notes:   Register offsets are byte addresses of 32-bit Wishbone words.
`default_nettype none

package serial_bit_io_pkg;

  // Wishbone register byte offsets.
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] MASK_OFS   = 4'h4;
  localparam logic [3:0] VIEW_OFS   = 4'h8;
  localparam logic [3:0] PORT_OFS   = 4'hc;

  // Event bit positions in the status and mask registers.
  localparam int EV_WRITE = 0;
  localparam int EV_READ  = 1;
  localparam int EV_MATCH = 2;
  localparam int EV_SKIP  = 3;
  localparam int EV_W     = 4;

  // Field positions of the view and port registers.
  localparam int VIEW_FLAG_BIT   = 8;
  localparam int VIEW_POL_BIT    = 9;
  localparam int VIEW_ACTIVE_BIT = 10;
  localparam int PORT_DIR_LSB    = 8;
  localparam int PORT_PIN_LSB    = 16;

  // Reset values.
  localparam logic [7:0]      DATA_RST = 8'h00;
  localparam logic [7:0]      DIR_RST  = 8'h00;
  localparam logic [1:0]      MODE_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // Compare modes.
  localparam logic [1:0] CMP_ANY_MISS  = 2'h0;
  localparam logic [1:0] CMP_ALL_MATCH = 2'h1;
  localparam logic [1:0] CMP_ALL_MISS  = 2'h2;
  localparam logic [1:0] CMP_ANY_MATCH = 2'h3;

  // Bit counts inside a serial byte.
  localparam logic [2:0] ID_LAST_BIT = 3'h1;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  // Control byte, most significant bit first.
  typedef struct packed {
    logic       identify_pin_high;
    logic       identify_pin_low;
    logic       register_select_bit;
    logic       write;
    logic       format_mask_bit;
    logic       format_setclear_bit;
    logic [1:0] compare_mode;
  } ctrl_s;

  // Serial link pins as one bundle for the synchroniser.
  typedef struct packed {
    logic ce_n;
    logic sck;
    logic mosi;
    logic id_high;
    logic id_low;
  } link_s;

endpackage

`default_nettype wire

// *** link_sync.sv ***
// Purpose: Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes: Each bit is an independent level; no bus coherence is promised.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module link_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  genvar g;

  // One two-stage chain per bit; reset value is low for every bit.
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_q;
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta_q    <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta_q    <= async_i[g];
          sync_o[g] <= meta_q;
        end
      end
    end
  endgenerate

endmodule // link_sync

`default_nettype wire

// *** port_compare.sv ***
// Purpose: Read view of the port and the compare condition.
// Assumes: Pin levels are already synchronised.
// Notes:   Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
`default_nettype none

module port_compare
  import serial_bit_io_pkg::*;
(
  // Register state and pins.
  input  wire logic [1:0] mode_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] dir_i,
  input  wire logic [7:0] pins_i,
  // Results.
  output logic      [7:0] view_o,
  output logic            flag_o
);

  logic [7:0] equal;

  // Inputs show the pin, outputs show the stored bit.
  assign view_o = (dir_i & data_i) | (~dir_i & pins_i);

  // An output pin always counts as equal to its register bit.
  assign equal = ~(view_o ^ data_i);

  // Four programmable conditions on the per-bit match vector.
  always_comb
  begin
    unique case (mode_i)
      CMP_ANY_MISS:  flag_o = ~&equal;
      CMP_ALL_MATCH: flag_o = &equal;
      CMP_ALL_MISS:  flag_o = ~|equal;
      CMP_ANY_MATCH: flag_o = |equal;
    endcase
  end

endmodule // port_compare

`default_nettype wire

// *** serial_bit_io_port_checker.sv ***
// Purpose: Concurrent checks on the serial bit I/O port's bus and pins.
// Assumes: Sees only top module ports; one clock domain.
// Notes:   Link figures allow for the two flop synchroniser.
`timescale 1ns/1ps
`default_nettype none

module serial_bit_io_port_checker (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bus.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  // Link and port.
  input  wire logic        ce_n_i,
  input  wire logic        miso_oe_o,
  input  wire logic [7:0]  port_pins_o,
  input  wire logic [7:0]  port_pins_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus handshake: one answer per request, one cycle after it is taken.
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_ack_prompt: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_upper_bits_zero: assert property (ack_o |-> dat_o[31:24] == 8'h00) else $error("unused read bits set");
  // The serial output is only driven inside a selected frame.
  a_miso_released: assert property (ce_n_i [*5] |-> !miso_oe_o) else $error("miso driven while idle");
  a_miso_after_select: assert property ($rose(miso_oe_o) |-> !$past(ce_n_i, 3))
    else $error("miso driven before select");
  // Pins move only as the result of a write byte inside a frame.
  a_pins_hold: assert property ($changed(port_pins_o) || $changed(port_pins_oe_o) |-> !$past(ce_n_i, 4))
    else $error("pins changed outside a frame");
  a_reset_inputs: assert property ($fell(rst_i) |-> port_pins_oe_o == 8'h00)
    else $error("pins driven after reset");

  // Main scenarios reached.
  c_miso: cover property ($rose(miso_oe_o));
  c_pins: cover property ($changed(port_pins_o));
  c_dir: cover property ($changed(port_pins_oe_o));
endmodule // serial_bit_io_port_checker

bind serial_bit_io_port serial_bit_io_port_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
  .ce_n_i, .miso_oe_o, .port_pins_o, .port_pins_oe_o);

`default_nettype wire

// *** spi_master_model.sv ***
// Purpose: Behavioural SPI master that frames bytes toward the port.
// Assumes: Clock phase one; either idle polarity; 160 ns bit period.
// Notes:   The clock stands still at its idle level outside frames.
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
  // Link toward the device.
  output logic      ce_n_o,
  output logic      sck_o,
  output logic      mosi_o,
  // Link from the device.
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  logic pol_q;
  logic last_q;

  // Idle link at time zero.
  initial
  begin
    ce_n_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
    pol_q = 1'b0;
    last_q = 1'b0;
  end

  // Settle the idle level before selecting, so the device latches it.
  task automatic start(input logic pol);
    pol_q = pol;
    sck_o = pol;
    #167;
    ce_n_o = 1'b0;
    #160;
  endtask

  // One byte, MSB first; a released line reads as the inverse of its last level.
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--)
    begin
      sck_o = ~pol_q;
      mosi_o = tx[b];
      #100;
      last_q = miso_oe_i ? miso_i : ~last_q;
      rx[b] = last_q;
      sck_o = pol_q;
      #60;
    end
  endtask

  // Deselect; the data line no longer carries the last bit.
  task automatic stop();
    #160;
    ce_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #160;
  endtask
endmodule // spi_master_model

`default_nettype wire

// *** serial_bit_io_port_tb.sv ***
// Purpose: Self-checking bench with a behavioural port model.
// Assumes: Wishbone master here; SPI master in its own model.
// Notes:   Random pins, ids and masks from a fixed LFSR seed.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module serial_bit_io_port_tb
  import serial_bit_io_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, q, r;
  logic        ce_n_i, sck_i, mosi_i, miso_o, miso_oe_o, identify_pin_high_i, identify_pin_low_i;
  logic [7:0]  port_pins_i, port_pins_o, port_pins_oe_o, ext, md, mr;
  logic [7:0]  lc;
  int          err_count, n_compared;

  // Driven bits read back the register; the rest float to the outside level.
  assign port_pins_i = (port_pins_o & port_pins_oe_o) | (ext & ~port_pins_oe_o);

  serial_bit_io_port DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .ce_n_i, .sck_i, .mosi_i, .miso_o, .miso_oe_o, .identify_pin_high_i, .identify_pin_low_i,
    .port_pins_i, .port_pins_o, .port_pins_oe_o, .irq_o);
  spi_master_model m (.ce_n_o(ce_n_i), .sck_o(sck_i), .mosi_o(mosi_i), .miso_i(miso_o), .miso_oe_i(miso_oe_o));

  // 50 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Output bits count as equal, so eq has ones there.
  function automatic logic flag(input logic [1:0] md_i, input logic [7:0] eq);
    case (md_i)
      CMP_ANY_MISS:  return eq != 8'hff;
      CMP_ALL_MATCH: return eq == 8'hff;
      CMP_ALL_MISS:  return eq == 8'h00;
      default:       return eq != 8'h00;
    endcase
  endfunction

  // Classic single cycle; the request holds until ack is sampled.
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] rd);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1)
    begin
      err_count++;
      end_of_test();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // One frame: control byte, data byte, one trailing byte.
  task automatic frame(input int i);
    logic [7:0] c, d, v, o, n, b0, b1, b2;
    logic [3:0] st;
    logic [1:0] id;
    logic       f, wr, rs, miss;
    r = lfsr(r);
    wr = i[1];
    rs = i[2];
    miss = (i % 7 == 5);
    id = r[13:12];
    d = r[23:16];
    c = {miss ? ~id : id, rs, wr, i[2] ^ i[3], i[3], i[3:2]};
    @(posedge clk_i);
    ext <= r[7:0];
    {identify_pin_high_i, identify_pin_low_i} <= id;
    wb(1'b1, MASK_OFS, 4'hf, {28'h0, r[27:24]}, q);
    v = (md & mr) | (r[7:0] & ~mr);
    f = flag(lc[1:0], ~(md ^ r[7:0]) | mr);
    o = rs ? mr : v;
    m.start(i[0]);
    m.xb(c, b0);
    m.xb(d, b1);
    m.xb(~d, b2);
    m.stop();
    if (!miss)
    begin
      `CHK("flag out", {6{f}}, b0[5:0])
      `CHK("byte out", o, b1)
      if (!wr)
        `CHK("repeat out", o, b2)
      else
        `CHK("released", {4{~o[0], o[0]}}, b2)
      lc = c;
    end
    else
      `CHK("skip quiet", {4{~b0[0], b0[0]}}, b1)
    n = c[3] ? (c[2] ? ((rs ? mr : md) | d) : ((rs ? mr : md) & ~d)) : d;
    if (!miss && wr && rs)
      mr = n;
    if (!miss && wr && !rs)
      md = n;
    st = {miss, f, !miss && !wr, !miss && wr};
    wb(1'b0, STATUS_OFS, 4'hf, 32'h0, q);
    `CHK("status", {28'h0, st}, q)
    `CHK("irq", |(st & r[27:24]), irq_o)
    wb(1'b0, PORT_OFS, 4'hf, 32'h0, q);
    `CHK("port", {8'h0, (md & mr) | (r[7:0] & ~mr), mr, md}, q)
    `CHK("pins", {mr, md}, {port_pins_oe_o, port_pins_o})
    wb(1'b0, VIEW_OFS, 4'hf, 32'h0, q);
    `CHK("view", {1'b0, i[0], f, lc}, q[10:0])
    wb(1'b1, STATUS_OFS, 4'hf, 32'hf, q);
    repeat (2) @(posedge clk_i);
    `CHK("irq clear", 1'b0, irq_o)
  endtask

  // Reset, idle checks, then frames through every mode, format and id.
  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 43'h0};
    {ext, md, mr, lc, identify_pin_high_i, identify_pin_low_i} = 34'h0;
    {err_count, n_compared, r} = {64'h0, 32'haddc};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, PORT_OFS, 4'hf, 32'h0, q);
    `CHK("port reset", 32'h0, q)
    wb(1'b1, MASK_OFS, 4'h0, 32'hf, q);
    wb(1'b0, MASK_OFS, 4'hf, 32'h0, q);
    `CHK("lane gated", 32'h0, q)
    wb(1'b0, 4'h2, 4'hf, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    for (int i = 0; i < 16; i++)
      frame(i);
    end_of_test();
  end
endmodule // serial_bit_io_port_tb

`default_nettype wire
